// ===== logic/bsbf_exec_unit.sv
`timescale 1ns/1ps
`include "bsbf_consts.svh"
module bsbf_exec_unit (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register port
    input bsbf_pkg::bsbf_axil_req_t axil_req,
    output bsbf_pkg::bsbf_axil_rsp_t axil_rsp
);
    import bsbf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Execution of one instruction on a snapshot of the state
    function automatic bsbf_out_t bsbf_exec(input bsbf_instr_t i, input logic [7:0] rd,
        input logic [7:0] rr, input logic [7:0] io, input logic [7:0] sr,
        input logic [15:0] pc, input logic [15:0] z);
        bsbf_out_t o;
        logic [8:0] d;
        logic [7:0] r;
        logic take;
        logic skip;
        logic shf;
        logic cin;
        o.pc = pc + 16'h0001;
        o.status_flags_reg = sr;
        o.result = rd;
        o.io = io;
        o.cycles = `BSBF_CYC_ONE;
        d = 9'h000;
        r = rd;
        take = 1'b0;
        skip = 1'b0;
        shf = 1'b0;
        cin = 1'b0;
        unique case (i.op)
            indirect_call_op: begin
                o.pc = z;
                o.cycles = `BSBF_CYC_THREE;
            end
            compare_skip_equal_op: skip = (rd == rr);
            compare_regs_op, compare_with_carry_op, compare_immediate_op: begin
                cin = (i.op == compare_with_carry_op) & sr[`BSBF_SR_C];
                d = {1'b0, rd} - {1'b0, rr} - {8'h00, cin};
                r = d[7:0];
                o.status_flags_reg[`BSBF_SR_C] = d[8];
                o.status_flags_reg[`BSBF_SR_Z] = (r == 8'h00)
                    & ((i.op != compare_with_carry_op) | sr[`BSBF_SR_Z]);
                o.status_flags_reg[`BSBF_SR_N] = r[7];
                o.status_flags_reg[`BSBF_SR_V] = (rd[7] & ~rr[7] & ~r[7]) | (~rd[7] & rr[7] & r[7]);
                o.status_flags_reg[`BSBF_SR_H] = (~rd[3] & rr[3]) | (rr[3] & r[3]) | (r[3] & ~rd[3]);
                o.status_flags_reg[`BSBF_SR_S] = o.status_flags_reg[`BSBF_SR_N] ^ o.status_flags_reg[`BSBF_SR_V];
            end
            skip_reg_bit_clear_op: skip = ~rd[i.bsel];
            skip_reg_bit_set_op: skip = rd[i.bsel];
            skip_io_bit_clear_op: skip = ~io[i.bsel];
            skip_io_bit_set_op: skip = io[i.bsel];
            branch_flag_set_op: take = sr[i.bsel];
            branch_flag_clear_op: take = ~sr[i.bsel];
            branch_same_higher_op: take = ~sr[`BSBF_SR_C];
            branch_lower_op: take = sr[`BSBF_SR_C];
            branch_signed_ge_op: take = ~(sr[`BSBF_SR_N] ^ sr[`BSBF_SR_V]);
            branch_signed_lt_op: take = sr[`BSBF_SR_N] ^ sr[`BSBF_SR_V];
            branch_irq_enabled_op: take = sr[`BSBF_SR_I];
            branch_irq_disabled_op: take = ~sr[`BSBF_SR_I];
            io_bit_set_op: begin
                o.io[i.bsel] = 1'b1;
                o.cycles = `BSBF_CYC_TWO;
            end
            io_bit_clear_op: begin
                o.io[i.bsel] = 1'b0;
                o.cycles = `BSBF_CYC_TWO;
            end
            rotate_left_carry_op: begin
                r = {rd[6:0], sr[`BSBF_SR_C]};
                o.status_flags_reg[`BSBF_SR_C] = rd[7];
                shf = 1'b1;
            end
            rotate_right_carry_op: begin
                r = {sr[`BSBF_SR_C], rd[7:1]};
                o.status_flags_reg[`BSBF_SR_C] = rd[0];
                shf = 1'b1;
            end
            logical_right_shift_op: begin
                r = {1'b0, rd[7:1]};
                o.status_flags_reg[`BSBF_SR_C] = rd[0];
                shf = 1'b1;
            end
            arith_right_shift_op: begin
                r = {rd[7], rd[7:1]};
                o.status_flags_reg[`BSBF_SR_C] = rd[0];
                shf = 1'b1;
            end
            nibble_swap_op: o.result = {rd[3:0], rd[7:4]};
            bit_to_tflag_op: o.status_flags_reg[`BSBF_SR_T] = rd[i.bsel];
            tflag_to_bit_op: o.result[i.bsel] = sr[`BSBF_SR_T];
            flag_set_op: o.status_flags_reg[i.bsel] = 1'b1;
            flag_clear_op: o.status_flags_reg[i.bsel] = 1'b0;
            default: o.cycles = `BSBF_CYC_ONE; // Unknown code acts as a no-op
        endcase
        // Common flag update of shifts and rotates
        if (shf) begin
            o.result = r;
            o.status_flags_reg[`BSBF_SR_Z] = (r == 8'h00);
            o.status_flags_reg[`BSBF_SR_N] = r[7];
            o.status_flags_reg[`BSBF_SR_V] = r[7] ^ o.status_flags_reg[`BSBF_SR_C];
            o.status_flags_reg[`BSBF_SR_S] = o.status_flags_reg[`BSBF_SR_N] ^ o.status_flags_reg[`BSBF_SR_V];
        end
        // Skip over a one- or two-word instruction
        if (skip) begin
            o.pc = pc + (i.long_next ? 16'h0003 : 16'h0002);
            o.cycles = i.long_next ? `BSBF_CYC_THREE : `BSBF_CYC_TWO;
        end
        // Relative branch, displacement is signed
        if (take) begin
            o.pc = pc + {{9{i.k[6]}}, i.k} + 16'h0001;
            o.cycles = `BSBF_CYC_TWO;
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State
    bsbf_instr_t instr_r;
    logic [7:0] rd_r, rr_r, io_r, status_flags_reg_r, result_r;
    logic [15:0] pc_r, zptr_r;
    logic [1:0] cnt_r;
    logic done_r;
    logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel decode
    wire busy = (cnt_r != 2'h0);
    wire commit = ce & (cnt_r == `BSBF_CYC_ONE);
    wire awready = ce & ~aw_full_r & ~bvalid_r;
    wire wready = ce & ~w_full_r & ~bvalid_r;
    wire aw_take = axil_req.awvalid & awready;
    wire w_take = axil_req.wvalid & wready;
    wire [7:0] wa = aw_full_r ? aw_addr_r : axil_req.awaddr;
    wire [31:0] wd = w_full_r ? w_data_r : axil_req.wdata;
    wire [3:0] ws = w_full_r ? w_strb_r : axil_req.wstrb;
    wire do_wr = ce & ~bvalid_r & (aw_full_r | aw_take) & (w_full_r | w_take);
    wire [31:0] wm = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire sel_instr = (wa == `BSBF_OFF_INSTR);
    wire sel_opnd = (wa == `BSBF_OFF_OPND);
    wire sel_zptr = (wa == `BSBF_OFF_ZPTR);
    wire sel_pc = (wa == `BSBF_OFF_PC);
    wire sel_status_flags_reg = (wa == `BSBF_OFF_STATUS_FLAGS_REG);
    wire sel_io = (wa == `BSBF_OFF_IO);
    wire sel_stat = (wa == `BSBF_OFF_STATUS);
    wire wr_map = sel_instr | sel_opnd | sel_zptr | sel_pc | sel_status_flags_reg | sel_io | sel_stat;
    wire wr_ok = wr_map & (~busy | sel_stat);
    wire wr_en = do_wr & wr_ok;
    wire launch = wr_en & sel_instr;
    wire done_clr = wr_en & sel_stat & wm[`BSBF_STAT_DONE] & wd[`BSBF_STAT_DONE];

    // Merged words and the instruction being launched
    wire [31:0] instr_word = {7'h00, instr_r.long_next, 1'b0, instr_r.k, 5'h00,
        instr_r.bsel, 3'h0, instr_r.op};
    wire [31:0] mi = (instr_word & ~wm) | (wd & wm);
    wire [31:0] mo = ({16'h0000, rr_r, rd_r} & ~wm) | (wd & wm);
    wire [31:0] mz = ({16'h0000, zptr_r} & ~wm) | (wd & wm);
    wire [31:0] mp = ({16'h0000, pc_r} & ~wm) | (wd & wm);
    wire [31:0] ms = ({24'h000000, status_flags_reg_r} & ~wm) | (wd & wm);
    wire [31:0] mio = ({24'h000000, io_r} & ~wm) | (wd & wm);
    wire bsbf_instr_t instr_w = '{long_next: mi[`BSBF_INSTR_LONG],
        k: mi[`BSBF_INSTR_K_MSB:`BSBF_INSTR_K_LSB],
        bsel: mi[`BSBF_INSTR_B_MSB:`BSBF_INSTR_B_LSB],
        op: bsbf_op_t'(mi[`BSBF_INSTR_OP_MSB:`BSBF_INSTR_OP_LSB])};
    wire bsbf_out_t ex_new = bsbf_exec(instr_w, rd_r, rr_r, io_r, status_flags_reg_r, pc_r, zptr_r);
    wire bsbf_out_t ex_cur = bsbf_exec(instr_r, rd_r, rr_r, io_r, status_flags_reg_r, pc_r, zptr_r);

    // Read channel decode
    wire arready = ce & ~rvalid_r;
    wire ar_take = axil_req.arvalid & arready;
    wire [7:0] ra = axil_req.araddr;
    wire rd_map = (ra == `BSBF_OFF_INSTR) | (ra == `BSBF_OFF_OPND) | (ra == `BSBF_OFF_ZPTR)
        | (ra == `BSBF_OFF_PC) | (ra == `BSBF_OFF_STATUS_FLAGS_REG) | (ra == `BSBF_OFF_IO)
        | (ra == `BSBF_OFF_RESULT) | (ra == `BSBF_OFF_STATUS);
    wire [31:0] rd_word = (ra == `BSBF_OFF_INSTR) ? instr_word
        : (ra == `BSBF_OFF_OPND) ? {16'h0000, rr_r, rd_r}
        : (ra == `BSBF_OFF_ZPTR) ? {16'h0000, zptr_r}
        : (ra == `BSBF_OFF_PC) ? {16'h0000, pc_r}
        : (ra == `BSBF_OFF_STATUS_FLAGS_REG) ? {24'h000000, status_flags_reg_r}
        : (ra == `BSBF_OFF_IO) ? {24'h000000, io_r}
        : (ra == `BSBF_OFF_RESULT) ? {24'h000000, result_r}
        : (ra == `BSBF_OFF_STATUS) ? {30'h0, done_r, busy} : 32'h00000000;

    assign axil_rsp = '{awready: awready, wready: wready, bresp: bresp_r, bvalid: bvalid_r,
        arready: arready, rdata: rdata_r, rresp: rresp_r, rvalid: rvalid_r};

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            bresp_r <= `BSBF_RESP_OKAY;
            rresp_r <= `BSBF_RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (ce) begin
            aw_full_r <= (aw_full_r | aw_take) & ~do_wr;
            w_full_r <= (w_full_r | w_take) & ~do_wr;
            if (aw_take) aw_addr_r <= axil_req.awaddr;
            if (w_take) w_data_r <= axil_req.wdata;
            if (w_take) w_strb_r <= axil_req.wstrb;
            bvalid_r <= do_wr | (bvalid_r & ~axil_req.bready);
            if (do_wr) bresp_r <= wr_ok ? `BSBF_RESP_OKAY : `BSBF_RESP_SLVERR;
            rvalid_r <= ar_take | (rvalid_r & ~axil_req.rready);
            if (ar_take) rdata_r <= rd_word;
            if (ar_take) rresp_r <= rd_map ? `BSBF_RESP_OKAY : `BSBF_RESP_SLVERR;
        end
    end

    // Software loads while idle, the core commits at the last busy cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            instr_r <= '0;
            {rr_r, rd_r} <= 16'h0000;
            zptr_r <= `BSBF_RST_PC;
            pc_r <= `BSBF_RST_PC;
            status_flags_reg_r <= `BSBF_RST_STATUS_FLAGS_REG;
            io_r <= `BSBF_RST_BYTE;
            result_r <= `BSBF_RST_BYTE;
            cnt_r <= 2'h0;
            done_r <= 1'b0;
        end else if (ce) begin
            if (launch) instr_r <= instr_w;
            if (wr_en & sel_opnd) {rr_r, rd_r} <= mo[15:0];
            if (wr_en & sel_zptr) zptr_r <= mz[15:0];
            if (wr_en & sel_pc) pc_r <= mp[15:0];
            if (wr_en & sel_status_flags_reg) status_flags_reg_r <= ms[7:0];
            if (wr_en & sel_io) io_r <= mio[7:0];
            cnt_r <= launch ? ex_new.cycles : (busy ? cnt_r - 2'h1 : 2'h0);
            if (commit) begin
                pc_r <= ex_cur.pc;
                status_flags_reg_r <= ex_cur.status_flags_reg;
                io_r <= ex_cur.io;
                result_r <= ex_cur.result;
            end
            done_r <= commit | (done_r & ~done_clr); // Set wins over clear
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);
    wire [15:0] k_sext = {{9{instr_r.k[6]}}, instr_r.k};
    wire [15:0] skip_step = instr_r.long_next ? 16'h0003 : 16'h0002;
    sequence s_busy3;
        busy [*3];
    endsequence
    sequence s_one_cycle;
        busy ##1 !busy;
    endsequence

    a_indirect_call_op_pc_z: assert property (launch && instr_w.op == indirect_call_op |=>
        s_busy3 ##1 (!busy && pc_r == zptr_r && status_flags_reg_r == $past(status_flags_reg_r, 4)))
        else $error("indirect call timing or target wrong");
    a_compare_skip_equal_op_skip: assert property (commit && instr_r.op == compare_skip_equal_op && rd_r == rr_r
        |=> pc_r == $past(pc_r) + skip_step && $stable(status_flags_reg_r))
        else $error("compare skip equal wrong");
    a_cmp_flags: assert property (commit && instr_r.op == compare_regs_op |=>
        status_flags_reg_r[`BSBF_SR_Z] == (rd_r == rr_r) && status_flags_reg_r[`BSBF_SR_C] == (rd_r < rr_r))
        else $error("compare flags wrong");
    a_cmp_one_cycle: assert property (launch && instr_w.op == compare_immediate_op
        |=> s_one_cycle)
        else $error("compare not one cycle");
    a_skip_reg_bit_set_op_skip: assert property (commit && instr_r.op == skip_reg_bit_set_op
        && rd_r[instr_r.bsel] |=> pc_r == $past(pc_r) + skip_step)
        else $error("register bit skip wrong");
    a_skip_io_bit_clear_op_skip: assert property (commit && instr_r.op == skip_io_bit_clear_op
        && !io_r[instr_r.bsel] |=> pc_r == $past(pc_r) + skip_step)
        else $error("io bit skip wrong");
    a_branch_flag_set_op_taken: assert property (commit && instr_r.op == branch_flag_set_op
        && status_flags_reg_r[instr_r.bsel] |=> pc_r == $past(pc_r) + k_sext + 16'h0001)
        else $error("flag branch target wrong");
    a_branch_signed_ge_op_nottaken: assert property (commit && instr_r.op == branch_signed_ge_op
        && (status_flags_reg_r[`BSBF_SR_N] ^ status_flags_reg_r[`BSBF_SR_V]) |=> pc_r == $past(pc_r) + 16'h0001)
        else $error("signed branch taken wrongly");
    a_sbi_bit: assert property (commit && instr_r.op == io_bit_set_op
        |=> io_r == ($past(io_r) | (8'h01 << instr_r.bsel)))
        else $error("io bit set wrong");
    a_rol_result: assert property (commit && instr_r.op == rotate_left_carry_op
        |=> result_r == {rd_r[6:0], $past(status_flags_reg_r[`BSBF_SR_C])})
        else $error("rotate left wrong");
    a_bst_tflag: assert property (commit && instr_r.op == bit_to_tflag_op
        |=> status_flags_reg_r == ({1'b0, rd_r[instr_r.bsel], $past(status_flags_reg_r[5:0])}
        | ($past(status_flags_reg_r) & 8'h80)))
        else $error("bit store wrong");
endmodule

// ===== logic/bsbf_consts.svh
`ifndef BSBF_CONSTS_SVH
`define BSBF_CONSTS_SVH
// Register byte offsets
`define BSBF_OFF_INSTR 8'h00
`define BSBF_OFF_OPND 8'h04
`define BSBF_OFF_ZPTR 8'h08
`define BSBF_OFF_PC 8'h0c
`define BSBF_OFF_STATUS_FLAGS_REG 8'h10
`define BSBF_OFF_IO 8'h14
`define BSBF_OFF_RESULT 8'h18
`define BSBF_OFF_STATUS 8'h1c
// Instruction word fields
`define BSBF_INSTR_OP_MSB 4
`define BSBF_INSTR_OP_LSB 0
`define BSBF_INSTR_B_MSB 10
`define BSBF_INSTR_B_LSB 8
`define BSBF_INSTR_K_MSB 22
`define BSBF_INSTR_K_LSB 16
`define BSBF_INSTR_LONG 24
// Status register fields
`define BSBF_STAT_BUSY 0
`define BSBF_STAT_DONE 1
// Flag positions in the status flags register
`define BSBF_SR_C 0
`define BSBF_SR_Z 1
`define BSBF_SR_N 2
`define BSBF_SR_V 3
`define BSBF_SR_S 4
`define BSBF_SR_H 5
`define BSBF_SR_T 6
`define BSBF_SR_I 7
// Reset values
`define BSBF_RST_PC 16'h0000
`define BSBF_RST_STATUS_FLAGS_REG 8'h00
`define BSBF_RST_BYTE 8'h00
// Cycle counts
`define BSBF_CYC_ONE 2'h1
`define BSBF_CYC_TWO 2'h2
`define BSBF_CYC_THREE 2'h3
// Bus responses
`define BSBF_RESP_OKAY 2'h0
`define BSBF_RESP_SLVERR 2'h2
`endif

// ===== logic/bsbf_pkg.sv
package bsbf_pkg;
    typedef enum logic [4:0] {
        indirect_call_op = 5'h00, compare_skip_equal_op = 5'h01,
        compare_regs_op = 5'h02, compare_with_carry_op = 5'h03,
        compare_immediate_op = 5'h04, skip_reg_bit_clear_op = 5'h05,
        skip_reg_bit_set_op = 5'h06, skip_io_bit_clear_op = 5'h07,
        skip_io_bit_set_op = 5'h08, branch_flag_set_op = 5'h09,
        branch_flag_clear_op = 5'h0a, branch_same_higher_op = 5'h0b,
        branch_lower_op = 5'h0c, branch_signed_ge_op = 5'h0d,
        branch_signed_lt_op = 5'h0e, branch_irq_enabled_op = 5'h0f,
        branch_irq_disabled_op = 5'h10, io_bit_set_op = 5'h11,
        io_bit_clear_op = 5'h12, rotate_left_carry_op = 5'h13,
        rotate_right_carry_op = 5'h14, logical_right_shift_op = 5'h15,
        arith_right_shift_op = 5'h16, nibble_swap_op = 5'h17,
        bit_to_tflag_op = 5'h18, tflag_to_bit_op = 5'h19,
        flag_set_op = 5'h1a, flag_clear_op = 5'h1b
    } bsbf_op_t;
    typedef struct packed {
        logic long_next;
        logic [6:0] k;
        logic [2:0] bsel;
        bsbf_op_t op;
    } bsbf_instr_t;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] status_flags_reg;
        logic [7:0] result;
        logic [7:0] io;
        logic [1:0] cycles;
    } bsbf_out_t;
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } bsbf_axil_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } bsbf_axil_rsp_t;
endpackage

// ===== verification/test_branch_skip_bit_flag_exec.sv
`timescale 1ns/1ps
module test_branch_skip_bit_flag_exec;
    import bsbf_pkg::*;
    logic aclk;
    logic aresetn;
    logic ce;
    bsbf_axil_req_t req;
    bsbf_axil_rsp_t rsp;
    int num_errors;
    int compares;
    int cyc = 0;
    int seed;
    int op;
    logic [7:0] rd, rr, sr, io, res, e_sr, e_io;
    logic [15:0] pc, zp, e_pc;
    logic [2:0] bs;
    logic [6:0] kk;
    logic lg;

    bsbf_exec_unit bsbf_exec_unit_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .axil_req(req),
        .axil_rsp(rsp)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors = num_errors + 1;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus tasks
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares = compares + 1;
        if (s !== e) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Address and data offered together, each dropped once taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        b = 1'b0;
        req.awaddr <= a;
        req.wdata <= d;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!b) begin
            @(negedge aclk);
            aw = req.awvalid && (rsp.awready === 1'b1);
            w = req.wvalid && (rsp.wready === 1'b1);
            b = rsp.bvalid === 1'b1;
            if (b) chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
            @(posedge aclk);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        logic ar, r;
        r = 1'b0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        while (!r) begin
            @(negedge aclk);
            ar = req.arvalid && (rsp.arready === 1'b1);
            r = rsp.rvalid === 1'b1;
            d = rsp.rdata;
            rs = rsp.rresp;
            @(posedge aclk);
            if (ar) req.arvalid <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model of one instruction
    task automatic predict();
        int d, s, t;
        logic c, tk;
        e_sr = sr;
        e_io = io;
        res = rd;
        e_pc = pc + 16'h0001;
        tk = 1'b0;
        c = sr[0];
        case (op)
            0: e_pc = zp;
            1: tk = rd == rr;
            2, 3, 4: begin
                t = (op == 3) ? int'(sr[0]) : 0;
                d = int'(rd) - int'(rr) - t;
                s = int'(rd[3:0]) - int'(rr[3:0]) - t;
                e_sr[0] = d < 0;
                e_sr[5] = s < 0;
                e_sr[2] = d[7];
                e_sr[3] = (rd[7] != rr[7]) && (d[7] != rd[7]);
                e_sr[1] = (d[7:0] == 8'h00) && (op != 3 || sr[1]);
                e_sr[4] = e_sr[2] ^ e_sr[3];
            end
            5: tk = !rd[bs];
            6: tk = rd[bs];
            7: tk = !io[bs];
            8: tk = io[bs];
            9: tk = sr[bs];
            10: tk = !sr[bs];
            11: tk = !sr[0];
            12: tk = sr[0];
            13: tk = !(sr[2] ^ sr[3]);
            14: tk = sr[2] ^ sr[3];
            15: tk = sr[7];
            16: tk = !sr[7];
            17: e_io[bs] = 1'b1;
            18: e_io[bs] = 1'b0;
            19: {c, res} = {rd, sr[0]};
            20: {res, c} = {sr[0], rd};
            21: {res, c} = {1'b0, rd};
            22: {res, c} = {rd[7], rd};
            23: res = {rd[3:0], rd[7:4]};
            24: e_sr[6] = rd[bs];
            25: res[bs] = sr[6];
            26: e_sr[bs] = 1'b1;
            27: e_sr[bs] = 1'b0;
            default: ;
        endcase
        if (op >= 19 && op <= 22) begin
            e_sr[0] = c;
            e_sr[1] = res == 8'h00;
            e_sr[2] = res[7];
            e_sr[3] = res[7] ^ c;
            e_sr[4] = e_sr[2] ^ e_sr[3];
        end
        if (tk && op >= 1 && op <= 8) e_pc = pc + (lg ? 16'h0003 : 16'h0002);
        if (tk && op >= 9 && op <= 16) e_pc = pc + {{9{kk[6]}}, kk} + 16'h0001;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v, w;
        logic [1:0] rs;
        int r, n;
        num_errors = 0;
        compares = 0;
        seed = 5980;
        aresetn = 1'b0;
        ce = 1'b1;
        req = '0;
        req.wstrb = 4'hf;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and an unmapped place
        bus_rd(8'h0c, v, rs);
        chk("pc after reset", v, 32'h0);
        bus_rd(8'h20, v, rs);
        chk("unmapped resp", {30'h0, rs}, 32'h2);
        chk("unmapped data", v, 32'h0);
        // Every code four times over random operands
        for (int i = 0; i < 128; i++) begin
            op = i % 32;
            r = $random(seed);
            {io, sr, rr, rd} = r;
            r = $random(seed);
            {zp, pc} = r;
            r = $random(seed);
            bs = r[2:0];
            kk = r[9:3];
            lg = r[10];
            if (r[11]) rr = rd;
            bus_wr(8'h04, {16'h0, rr, rd}, 2'h0);
            bus_wr(8'h08, {16'h0, zp}, 2'h0);
            bus_wr(8'h0c, {16'h0, pc}, 2'h0);
            bus_wr(8'h10, {24'h0, sr}, 2'h0);
            bus_wr(8'h14, {24'h0, io}, 2'h0);
            w = 32'h0;
            w[4:0] = op[4:0];
            w[10:8] = bs;
            w[22:16] = kk;
            w[24] = lg;
            bus_wr(8'h00, w, 2'h0);
            // Enable held low for three edges: execution must stay frozen meanwhile
            if (i[5]) begin
                ce <= 1'b0;
                repeat (3) @(posedge aclk);
                ce <= 1'b1;
            end
            // A long call is still running, so a register write is refused
            if (op == 0) bus_wr(8'h0c, 32'h0000_5a5a, 2'h2);
            n = 0;
            v = 32'h0;
            while (v[1] !== 1'b1 && n < 40) begin
                bus_rd(8'h1c, v, rs);
                n++;
            end
            chk("status", v, 32'h2);
            predict();
            bus_rd(8'h0c, v, rs);
            chk("pc", v, {16'h0, e_pc});
            bus_rd(8'h10, v, rs);
            chk("flags", v, {24'h0, e_sr});
            bus_rd(8'h18, v, rs);
            chk("result", v, {24'h0, res});
            bus_rd(8'h14, v, rs);
            chk("io", v, {24'h0, e_io});
            bus_wr(8'h1c, 32'h2, 2'h0);
        end
        end_sim();
    end
endmodule
